// ==== logic/drr_regs.sv ====
// dma request routing: address, byte-count and alternating-channel registers
`timescale 1ns/100ps
`default_nettype none
module drr_regs
  (
  input  wire logic                  clk_sys,    // 40 MHz clock
  input  wire logic                  rst_n,      // async reset, low
  input  wire logic [drr_pkg::DRR_AW-1:0] regAddr, // register address
  input  wire logic [drr_pkg::DRR_DW-1:0] regWdata, // write data
  input  wire logic                  regWr,      // write strobe
  input  wire logic                  regRd,      // read strobe
  output logic [drr_pkg::DRR_DW-1:0] regRdata,   // read data, cycle after strobe
  input  wire drr_pkg::drr_req_type  reqIn,      // raw request sources (pins, flags)
  input  wire logic                  ch0Xfer,    // channel 0 moved one byte
  input  wire logic                  ch1Xfer,    // channel 1 moved one byte
  output drr_pkg::drr_grant_type     reqOut,     // routed requests per channel
  output logic [19:0]                ch0SrcAddr, // channel 0 source address
  output logic [15:0]                ch1IoAddr,  // channel 1 I/O address
  output logic                       ch0End,     // channel 0 end pulse
  output logic                       ch1End      // channel 1 end pulse
  );
  import drr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [19:0] srcAddr_r;
  logic [15:0] count0_r;
  logic [15:0] count1_r;
  logic [15:0] ioAddr_r;
  logic [7:0]  ioCtrl_r;
  logic        run0_r;
  logic        run1_r;
  logic        ch1Dir_r;
  logic        ch0Io_r;
  logic        swapCur_r;
  logic [DRR_DW-1:0] rdata_r;
  drr_grant_type reqOut_r;
  logic        end0_r;
  logic        end1_r;
  drr_req_type reqMeta_r;
  drr_req_type reqSync_r;

  // pins and serial flags come from outside: two flops before use
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqMeta_r <= '0;
      reqSync_r <= '0;
    end
    else
    begin
      reqMeta_r <= reqIn;
      reqSync_r <= reqMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request selection

  // ch0 source select
  function automatic logic pickCh0(input logic [1:0] sel, input drr_req_type r);
    case (sel)
      2'h0:    pickCh0 = r.extPin0;
      2'h1:    pickCh0 = r.rxFull0;
      2'h2:    pickCh0 = r.rxFull1;
      default: pickCh0 = 1'b0;
    endcase
  endfunction

  // ch1 select, direction chooses rx or tx flags
  function automatic logic pickCh1(input logic [2:0] sel, input logic dirSrc,
                                   input drr_req_type r);
    case (sel)
      3'h0:    pickCh1 = r.extPin1;
      3'h1:    pickCh1 = dirSrc ? r.rxFull0 : r.txEmpty0;
      3'h2:    pickCh1 = dirSrc ? r.rxFull1 : r.txEmpty1;
      default: pickCh1 = 1'b0;
    endcase
  endfunction

  logic swapEn;
  logic sel0;
  logic sel1;
  logic done0;
  logic done1;
  logic wrCh0Count;
  logic wrCh1Count;
  logic wrRun;
  logic wrCtrl;
  assign swapEn = ioCtrl_r[DRR_BIT_SWAP_EN];
  assign sel0 = ch0Io_r ? pickCh0(srcAddr_r[17:16], reqSync_r) : 1'b0;
  assign sel1 = pickCh1(ioCtrl_r[2:0], ch1Dir_r, reqSync_r);
  // last byte brings counter to zero
  assign done0 = run0_r && ch0Xfer && (count0_r == 16'h0001);
  assign done1 = run1_r && ch1Xfer && (count1_r == 16'h0001);
  assign wrCh0Count = regWr && (regAddr == DRR_OFS_BC0_LOW || regAddr == DRR_OFS_BC0_HIGH);
  assign wrCh1Count = regWr && (regAddr == DRR_OFS_BC1_LOW || regAddr == DRR_OFS_BC1_HIGH);
  // one decode each for the run register and the channel 1 control byte
  assign wrRun      = regWr && (regAddr == DRR_OFS_RUN);
  assign wrCtrl     = regWr && (regAddr == DRR_OFS_IO1_CTRL);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqOut_r <= '0;
    end
    else
    begin
      // pin to grant takes three edges: two to synchronise, one to route
      // swap off: current bit ignored
      reqOut_r.ch0Req <= sel0 && run0_r && !(swapEn && swapCur_r);
      reqOut_r.ch1Req <= sel1 && run1_r && !(swapEn && !swapCur_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address registers

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcAddr_r <= DRR_RST_ADDR;
    end
    else if (regWr)
    begin
      case (regAddr)
        DRR_OFS_SAR_LOW:   srcAddr_r[7:0]   <= regWdata;
        DRR_OFS_SAR_HIGH:  srcAddr_r[15:8]  <= regWdata;
        DRR_OFS_SAR_UPPER: srcAddr_r[19:16] <= regWdata[3:0];
        default:           srcAddr_r        <= srcAddr_r;
      endcase
    end
  end

  // bit 6 of the stored control byte goes unread: the swap-current flop owns it
  // channel 1 I/O address and control byte
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ioAddr_r <= DRR_RST_COUNT;
      ioCtrl_r <= DRR_RST_BYTE;
    end
    else if (regWr)
    begin
      case (regAddr)
        DRR_OFS_IO1_LOW:  ioAddr_r[7:0]  <= regWdata;
        DRR_OFS_IO1_HIGH: ioAddr_r[15:8] <= regWdata;
        DRR_OFS_IO1_CTRL: ioCtrl_r       <= regWdata;
        default:          ioCtrl_r       <= ioCtrl_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternating channel

  // channel end beats a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swapCur_r <= 1'b0;
    end
    else if (swapEn && done0)
    begin
      swapCur_r <= 1'b1;
    end
    else if (swapEn && done1)
    begin
      swapCur_r <= 1'b0;
    end
    // software picks the first channel; only meant while both are stopped
    else if (wrCtrl)
    begin
      swapCur_r <= regWdata[DRR_BIT_SWAP_CUR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte counters

  // counters take no reset: value undefined until written
  // load by software, decrement per byte
  // a write beats a byte moved in the same cycle; that byte goes uncounted
  // a loaded zero wraps and runs 65536 bytes before the end comes round
  always_ff @(posedge clk_sys)
  begin
    if (wrCh0Count && regAddr == DRR_OFS_BC0_LOW)
    begin
      count0_r[7:0] <= regWdata;
    end
    else if (wrCh0Count)
    begin
      count0_r[15:8] <= regWdata;
    end
    else if (run0_r && ch0Xfer)
    begin
      count0_r <= count0_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wrCh1Count && regAddr == DRR_OFS_BC1_LOW)
    begin
      count1_r[7:0] <= regWdata;
    end
    else if (wrCh1Count)
    begin
      count1_r[15:8] <= regWdata;
    end
    else if (run1_r && ch1Xfer)
    begin
      count1_r <= count1_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run bits and channel end

  // end stops the channel, wins over a write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run0_r <= 1'b0;
    end
    else if (done0)
    begin
      run0_r <= 1'b0;
    end
    else if (wrRun)
    begin
      run0_r <= regWdata[DRR_BIT_CH0_RUN];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run1_r <= 1'b0;
    end
    else if (done1)
    begin
      run1_r <= 1'b0;
    end
    else if (wrRun)
    begin
      run1_r <= regWdata[DRR_BIT_CH1_RUN];
    end
  end

  // channel configuration bits share the run register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch1Dir_r <= 1'b0;
      ch0Io_r  <= 1'b0;
    end
    else if (wrRun)
    begin
      ch1Dir_r <= regWdata[DRR_BIT_CH1_DIR];
      ch0Io_r  <= regWdata[DRR_BIT_CH0_IO];
    end
  end

  // end pulses, one cycle after the last byte
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      end0_r <= 1'b0;
    end
    else
    begin
      end0_r <= done0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      end1_r <= 1'b0;
    end
    else
    begin
      end1_r <= done1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= DRR_RST_BYTE;
    end
    else if (regRd)
    begin
      case (regAddr)
        DRR_OFS_SAR_LOW:   rdata_r <= srcAddr_r[7:0];
        DRR_OFS_SAR_HIGH:  rdata_r <= srcAddr_r[15:8];
        DRR_OFS_SAR_UPPER: rdata_r <= {4'h0, srcAddr_r[19:16]};
        DRR_OFS_BC0_LOW:   rdata_r <= count0_r[7:0];
        DRR_OFS_BC0_HIGH:  rdata_r <= count0_r[15:8];
        DRR_OFS_IO1_LOW:   rdata_r <= ioAddr_r[7:0];
        DRR_OFS_IO1_HIGH:  rdata_r <= ioAddr_r[15:8];
        DRR_OFS_IO1_CTRL:  rdata_r <= {ioCtrl_r[7], swapCur_r, ioCtrl_r[5:0]};
        DRR_OFS_BC1_LOW:   rdata_r <= count1_r[7:0];
        DRR_OFS_BC1_HIGH:  rdata_r <= count1_r[15:8];
        DRR_OFS_RUN:       rdata_r <= {4'h0, ch0Io_r, ch1Dir_r, run1_r, run0_r};
        default:           rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      rdata_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign regRdata   = rdata_r;
  assign reqOut     = reqOut_r;
  assign ch0SrcAddr = srcAddr_r;
  assign ch1IoAddr  = ioAddr_r;
  assign ch0End     = end0_r;
  assign ch1End     = end1_r;

endmodule
`default_nettype wire

// ==== logic/drr_pkg.sv ====
// package: offsets, fields and reset values of the dma request routing registers
package drr_pkg;

  localparam int DRR_AW = 8;
  localparam int DRR_DW = 8;

  localparam logic [7:0] DRR_OFS_SAR_LOW   = 8'h20;
  localparam logic [7:0] DRR_OFS_SAR_HIGH  = 8'h21;
  localparam logic [7:0] DRR_OFS_SAR_UPPER = 8'h22;
  localparam logic [7:0] DRR_OFS_BC0_LOW   = 8'h26;
  localparam logic [7:0] DRR_OFS_BC0_HIGH  = 8'h27;
  localparam logic [7:0] DRR_OFS_IO1_LOW   = 8'h2b;
  localparam logic [7:0] DRR_OFS_IO1_HIGH  = 8'h2c;
  localparam logic [7:0] DRR_OFS_IO1_CTRL  = 8'h2d;
  localparam logic [7:0] DRR_OFS_BC1_LOW   = 8'h2e;
  localparam logic [7:0] DRR_OFS_BC1_HIGH  = 8'h2f;
  // run and status register, a block-local addition
  localparam logic [7:0] DRR_OFS_RUN       = 8'h30;

  // fields of the channel 1 control byte
  localparam int DRR_BIT_SWAP_EN  = 7;
  localparam int DRR_BIT_SWAP_CUR = 6;
  // fields of the run register
  localparam int DRR_BIT_CH0_RUN  = 0;
  localparam int DRR_BIT_CH1_RUN  = 1;
  localparam int DRR_BIT_CH1_DIR  = 2;
  localparam int DRR_BIT_CH0_IO   = 3;

  localparam logic [7:0]  DRR_RST_BYTE  = 8'h00;
  localparam logic [19:0] DRR_RST_ADDR  = 20'h00000;
  localparam logic [15:0] DRR_RST_COUNT = 16'h0000;

  typedef struct packed {
    logic extPin0;
    logic extPin1;
    logic rxFull0;
    logic rxFull1;
    logic txEmpty0;
    logic txEmpty1;
  } drr_req_type;

  typedef struct packed {
    logic ch0Req;
    logic ch1Req;
  } drr_grant_type;

endpackage

// ==== verif/drr_far_side.sv ====
// far side model: request sources and a byte mover serving routed requests
`timescale 1ns/100ps
`default_nettype none
module drr_far_side
  import drr_pkg::*;
  (
  input  wire logic          clk_sys,  // clock
  input  wire logic          rst_n,    // reset, low
  input  wire logic [5:0]    srcLevel, // source levels
  input  wire logic          slow,     // gap between bytes
  input  wire logic          xferEn,   // serve requests
  input  wire drr_grant_type reqOut,   // routed requests
  output drr_req_type        reqIn,    // pins and flags
  output logic               ch0Xfer,  // channel 0 byte
  output logic               ch1Xfer   // channel 1 byte
  );
  assign reqIn = drr_req_type'(srcLevel);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0Xfer <= 1'b0;
      ch1Xfer <= 1'b0;
    end
    else
    begin
      ch0Xfer <= xferEn && reqOut.ch0Req && !(slow && ch0Xfer);
      ch1Xfer <= xferEn && reqOut.ch1Req && !(slow && ch1Xfer);
    end
  end
endmodule
`default_nettype wire

// ==== verif/drr_regs_asserts.sv ====
// checker: port-level assertions for the request routing registers
`timescale 1ns/100ps
`default_nettype none
module drr_regs_asserts
  import drr_pkg::*;
  (
  input wire logic          clk_sys,    // clock
  input wire logic          rst_n,      // reset, low
  input wire logic [7:0]    regAddr,    // address
  input wire logic [7:0]    regWdata,   // write data
  input wire logic          regWr,      // write strobe
  input wire logic          regRd,      // read strobe
  input wire logic [7:0]    regRdata,   // read data
  input wire logic          ch0Xfer,    // ch0 byte
  input wire logic          ch1Xfer,    // ch1 byte
  input wire drr_grant_type reqOut,     // routed requests
  input wire logic [19:0]   ch0SrcAddr, // ch0 address
  input wire logic [15:0]   ch1IoAddr,  // ch1 address
  input wire logic          ch0End,     // ch0 end
  input wire logic          ch1End      // ch1 end
  );
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sar_low_map_a: assert property (regWr && regAddr == 8'h20 |=>
    ch0SrcAddr[7:0] == $past(regWdata)) else $error("source low byte wrong");
  sar_select_map_a: assert property (regWr && regAddr == 8'h22 |=>
    ch0SrcAddr[19:16] == $past(regWdata[3:0])) else $error("source upper bits wrong");
  io_high_map_a: assert property (regWr && regAddr == 8'h2c |=>
    ch1IoAddr[15:8] == $past(regWdata)) else $error("io high byte wrong");
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  end0_cause_a: assert property (ch0End |-> $past(ch0Xfer))
    else $error("ch0 end without a byte");
  end1_cause_a: assert property (ch1End |-> $past(ch1Xfer))
    else $error("ch1 end without a byte");
  end0_stop_a: assert property (ch0End |=> !reqOut.ch0Req && !ch0End)
    else $error("ch0 still requested after end");
  end1_stop_a: assert property (ch1End |=> !reqOut.ch1Req && !ch1End)
    else $error("ch1 still requested after end");
  cover property (ch0End);
  cover property (ch1End);
  cover property (reqOut.ch0Req && regRd);
endmodule
bind drr_regs drr_regs_asserts i_drr_regs_asserts (.clk_sys, .rst_n, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .ch0Xfer, .ch1Xfer, .reqOut, .ch0SrcAddr,
  .ch1IoAddr, .ch0End, .ch1End);
`default_nettype wire

// ==== verif/drr_regs_tb.sv ====
// testbench: registers, request routing and alternating channels
`timescale 1ns/100ps
`default_nettype none
module drr_regs_tb;
  import drr_pkg::*;
  logic clk_sys, rst_n, regWr, regRd, slow, xferEn, ch0Xfer, ch1Xfer, ch0End, ch1End;
  logic [7:0]    regAddr, regWdata, regRdata;
  logic [5:0]    srcLevel;
  logic [19:0]   ch0SrcAddr;
  logic [15:0]   ch1IoAddr;
  drr_req_type   reqIn;
  drr_grant_type reqOut;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] ofs [10] = '{8'h20, 8'h21, 8'h22, 8'h26, 8'h27, 8'h2b, 8'h2c, 8'h2d,
    8'h2e, 8'h2f};
  logic [5:0] src0 [4] = '{6'h20, 6'h08, 6'h04, 6'h00};
  logic [5:0] dst1 [4] = '{6'h10, 6'h02, 6'h01, 6'h00};
  logic [5:0] src1 [4] = '{6'h10, 6'h08, 6'h04, 6'h00};
  drr_regs i_drr_regs (.clk_sys, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .reqIn, .ch0Xfer, .ch1Xfer, .reqOut, .ch0SrcAddr, .ch1IoAddr, .ch0End, .ch1End);
  drr_far_side i_drr_far_side (.clk_sys, .rst_n, .srcLevel, .slow, .xferEn, .reqOut,
    .reqIn, .ch0Xfer, .ch1Xfer);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [19:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk($sformatf("reg %h", a), regRdata, e);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    foreach (ofs[i]) wr(ofs[i], ofs[i] ^ 8'hc3);
    wr(8'h30, 8'hf4);
    foreach (ofs[i]) rc(ofs[i], ofs[i] == 8'h22 ? 8'h01 : ofs[i] ^ 8'hc3);
    rc(8'h30, 8'h04);
    rc(8'h23, 8'h00);
    chk("source address", ch0SrcAddr, 20'h1e2e3);
    chk("io address", ch1IoAddr, 16'hefe8);
    $display("done: registers");
  endtask
  // each select code: others high gives nothing, the chosen source alone passes
  task automatic t_route(input logic [7:0] run, selReg, input logic [5:0] tbl [4],
    input logic ch1);
    wr(8'h30, run);
    for (int s = 0; s < 4; s++)
    begin
      wr(selReg, 8'(s));
      srcLevel <= ~tbl[s];
      repeat (5) @(negedge clk_sys);
      chk("blocked", ch1 ? reqOut.ch1Req : reqOut.ch0Req, 1'b0);
      @(posedge clk_sys);
      srcLevel <= tbl[s];
      repeat (5) @(negedge clk_sys);
      chk("routed", ch1 ? reqOut.ch1Req : reqOut.ch0Req, s != 3);
    end
    $display("done: routing");
  endtask
  task automatic t_swap(input logic [7:0] ctrl, input logic slw);
    logic e0;
    logic e1;
    int n;
    e0 = 1'b0;
    e1 = 1'b0;
    n = 0;
    // both channels stopped before the swap bits are written
    wr(8'h30, 8'h00);
    wr(8'h26, 8'h01);
    xferEn <= 1'b0;
    slow <= slw;
    wr(8'h27, 8'h00);
    wr(8'h2e, 8'h02);
    wr(8'h2f, 8'h00);
    wr(8'h22, 8'h00);
    // swap chosen while stopped, one device on both pins
    wr(8'h2d, ctrl);
    srcLevel <= 6'h30;
    // channel 0 takes extPin0 and channel 1 takes extPin1, both pins driven high
    wr(8'h30, 8'h0f);
    repeat (3) @(negedge clk_sys);
    chk("ch0 request", reqOut.ch0Req, !ctrl[6]);
    chk("ch1 request", reqOut.ch1Req, ctrl[6]);
    @(posedge clk_sys);
    xferEn <= 1'b1;
    while (!(e0 && e1) && n < 60)
    begin
      @(negedge clk_sys);
      e0 |= ch0End === 1'b1;
      e1 |= ch1End === 1'b1;
      n++;
    end
    chk("both ends", {e0, e1}, 2'b11);
    rc(8'h2d, ctrl);
    rc(8'h30, 8'h0c);
    rc(8'h26, 8'h00);
    rc(8'h2e, 8'h00);
    $display("done: alternating");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    mismatches++;
    final_report;
  end
  initial
  begin
    {rst_n, regWr, regRd, slow, xferEn} = '0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    srcLevel = 6'h00;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    // swap current set but swap off must not block channel 0
    wr(8'h2d, 8'h40);
    t_route(8'h09, 8'h22, src0, 1'b0);
    t_route(8'h02, 8'h2d, dst1, 1'b1);
    t_route(8'h06, 8'h2d, src1, 1'b1);
    t_swap(8'h80, 1'b0);
    t_swap(8'hc0, 1'b1);
    final_report;
  end
endmodule
`default_nettype wire
